// File: include/lens_cmd_pkg.sv
package lens_cmd_pkg;
    // message framing characters
    localparam logic [7:0] CH_INSTR  = 8'h3C;
    localparam logic [7:0] CH_QUERY  = 8'h3F;
    localparam logic [7:0] CH_SEP    = 8'h3B;
    localparam logic [7:0] CH_NOSUM  = 8'h2A;
    localparam logic [7:0] CH_TERM   = 8'h3E;
    localparam logic [7:0] CH_DIG0   = 8'h30;
    localparam logic [7:0] CH_DIG9   = 8'h39;
    localparam logic [7:0] CH_UPA    = 8'h41;
    localparam logic [7:0] CH_UPF    = 8'h46;
    localparam logic [7:0] CH_LOA    = 8'h61;
    localparam logic [7:0] CH_LOF    = 8'h66;
    localparam logic [7:0] HEX_TEN   = 8'h0A;
    // command letters: axis first, action second
    localparam logic [7:0] CH_MAIN   = 8'h5A;
    localparam logic [7:0] CH_SLAVE  = 8'h59;
    localparam logic [7:0] CH_FOCUS  = 8'h46;
    localparam logic [7:0] CH_SET    = 8'h53;
    localparam logic [7:0] CH_GOTO   = 8'h50;
    localparam logic [7:0] CH_RUN    = 8'h52;
    // axes
    localparam int         NUM_AXES  = 3;
    localparam logic [1:0] AX_MAIN   = 2'h0;
    localparam logic [1:0] AX_SLAVE  = 2'h1;
    localparam logic [1:0] AX_FOCUS  = 2'h2;
    // parameter limits and rate interpretation
    localparam logic [16:0] POS_MAX  = 17'h00FFF;
    localparam logic [11:0] RATE_MAX = 12'h0FF;
    localparam logic [7:0]  RATE_MID = 8'h7F;
    localparam logic [7:0]  DEADBAND = 8'h0A;
    localparam logic [3:0]  DEC_BASE = 4'hA;

    typedef enum logic [1:0] {K_RATE_SET, K_GOTO, K_RATE_RUN, K_BAD} kind_e;
    typedef enum logic [1:0] {MODE_STOP, MODE_RATE, MODE_GOTO} mode_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_CODE_HI, ST_CODE_LO, ST_PARAM,
        ST_CK_HI, ST_CK_LO, ST_TERM, ST_FLUSH
    } state_e;
endpackage : lens_cmd_pkg

// File: hdl/lens_cmd_parser.sv
`timescale 1ns/1ps
// Functional notes
// - host starts; every complete command gets exactly one response
// - unparsable message gets an error response, nothing executes
// - message opens with '<' for instruction or '?' for query
// - two uppercase letters from the supported set follow the opener
// - optional decimal parameter; omitted means zero
// - then ';', two hex digits or '**', then '>'
// - checksum is byte sum mod 256 from opener through ';'
// - act only when the terminating '>' arrives
// - positions 0..4095, rates 0..255
// - rate parameter of 256 or more is ignored with an error
// - rate 127 stops, above forward, below backward, deadband about 10
// - valid query reports only; query on other command executes it
// - main zoom rate set stores rate and stops the motor
// - main zoom goto drives to 0..4095 target; queryable
// - main zoom rate run loads rate and starts motor
// - slave rate set stores rate; no effect while linked
// - slave goto waits while linked, applied on unlink; queryable
// - slave rate run starts motor unless linked to main zoom
// - focus rate set stores rate and stops the motor
// - focus goto drives to 0..4095 target; queryable
// - after reset motors disabled and slave unlinked
module lens_cmd_parser (
    input  wire logic                                   i_ref_clk,
    input  wire logic                                   i_reset_n,
    input  wire logic [7:0]                             i_rx_data,
    input  wire logic                                   i_rx_valid,
    input  wire logic                                   i_motor_enable,
    input  wire logic                                   i_slave_link,
    output logic                                        o_resp_valid,
    output logic                                        o_resp_error,
    output logic                                        o_resp_query,
    output logic [11:0]                                 o_resp_value,
    output logic [lens_cmd_pkg::NUM_AXES-1:0][7:0]      o_axis_rate,
    output logic [lens_cmd_pkg::NUM_AXES-1:0][11:0]     o_axis_target,
    output logic [lens_cmd_pkg::NUM_AXES-1:0]           o_axis_fwd,
    output logic [lens_cmd_pkg::NUM_AXES-1:0]           o_axis_rev,
    output logic [lens_cmd_pkg::NUM_AXES-1:0]           o_axis_goto
);
    import lens_cmd_pkg::*;

    function automatic logic is_digit(input logic [7:0] b);
        return (b >= CH_DIG0) && (b <= CH_DIG9);
    endfunction : is_digit

    function automatic logic is_hex(input logic [7:0] b);
        return is_digit(b) || ((b >= CH_UPA) && (b <= CH_UPF))
            || ((b >= CH_LOA) && (b <= CH_LOF));
    endfunction : is_hex

    function automatic logic [3:0] hex_val(input logic [7:0] b);
        logic [7:0] v;
        v = 8'h00;
        if (is_digit(b)) v = b - CH_DIG0;
        else if (b >= CH_LOA) v = b - CH_LOA + HEX_TEN;
        else v = b - CH_UPA + HEX_TEN;
        return v[3:0];
    endfunction : hex_val

    // motion direction of a rate around the midpoint
    function automatic logic [1:0] rate_dir(input logic [7:0] r);
        return {r > (RATE_MID + DEADBAND), r < (RATE_MID - DEADBAND)};
    endfunction : rate_dir

    function automatic mode_e mode_of(input kind_e k);
        case (k)
            K_RATE_RUN: return MODE_RATE;
            K_GOTO:     return MODE_GOTO;
            default:    return MODE_STOP;
        endcase
    endfunction : mode_of

    ////////////////////////////////////////////////////////////////////////
    state_e      state_reg;
    logic [7:0]  code_hi_reg, code_lo_reg, sum_reg, ck_reg;
    logic [11:0] param_reg;
    logic        query_reg, ovf_reg, bypass_reg;
    logic        rx_term, fire, cmd_ok, range_ok, sum_ok, good, act;
    logic [1:0]  cmd_axis;
    kind_e       cmd_kind;
    logic [16:0] param_next;

    assign rx_term    = i_rx_valid && (i_rx_data == CH_TERM);
    assign param_next = 17'(param_reg) * 17'(DEC_BASE)
                      + 17'(i_rx_data - CH_DIG0);

    // a stray '>' outside a message is ignored, it starts nothing
    assign fire = rx_term && (state_reg != ST_IDLE);

    always_comb begin
        cmd_axis = AX_MAIN;
        cmd_kind = K_BAD;
        case (code_lo_reg)
            CH_SET:  cmd_kind = K_RATE_SET;
            CH_GOTO: cmd_kind = K_GOTO;
            CH_RUN:  cmd_kind = K_RATE_RUN;
            default: cmd_kind = K_BAD;
        endcase
        case (code_hi_reg)
            CH_MAIN:  cmd_axis = AX_MAIN;
            CH_SLAVE: cmd_axis = AX_SLAVE;
            CH_FOCUS: begin
                cmd_axis = AX_FOCUS;
                if (cmd_kind == K_RATE_RUN) cmd_kind = K_BAD;
            end
            default:  cmd_kind = K_BAD;
        endcase
    end

    assign cmd_ok   = (cmd_kind != K_BAD);
    assign range_ok = !ovf_reg && ((cmd_kind == K_GOTO)
                    || (param_reg <= RATE_MAX));
    assign sum_ok   = bypass_reg || (ck_reg == sum_reg);
    assign good     = (state_reg == ST_TERM) && cmd_ok && range_ok
                    && sum_ok;
    // a valid query only reports; any other valid command executes on '>'
    assign act      = fire && good
                    && !(query_reg && (cmd_kind == K_GOTO));

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
        end else if (fire) begin
            state_reg <= ST_IDLE;
        end else if (i_rx_valid) begin
            case (state_reg)
                ST_IDLE: if (i_rx_data == CH_INSTR
                             || i_rx_data == CH_QUERY) state_reg <= ST_CODE_HI;
                ST_CODE_HI: state_reg <= ST_CODE_LO;
                ST_CODE_LO: state_reg <= ST_PARAM;
                ST_PARAM: begin
                    if (i_rx_data == CH_SEP) state_reg <= ST_CK_HI;
                    else if (!is_digit(i_rx_data)) state_reg <= ST_FLUSH;
                end
                ST_CK_HI: state_reg <= (i_rx_data == CH_NOSUM
                    || is_hex(i_rx_data)) ? ST_CK_LO : ST_FLUSH;
                ST_CK_LO: state_reg <= (bypass_reg ? i_rx_data == CH_NOSUM
                    : is_hex(i_rx_data)) ? ST_TERM : ST_FLUSH;
                ST_TERM:  state_reg <= ST_FLUSH;
                ST_FLUSH: state_reg <= ST_FLUSH;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            code_hi_reg <= 8'h00;
            code_lo_reg <= 8'h00;
            query_reg   <= 1'b0;
        end else if (i_rx_valid) begin
            if (state_reg == ST_IDLE)
                query_reg <= (i_rx_data == CH_QUERY);
            if (state_reg == ST_CODE_HI)
                code_hi_reg <= i_rx_data;
            if (state_reg == ST_CODE_LO)
                code_lo_reg <= i_rx_data;
        end
    end

    // parameter accumulates in decimal; overflow past 4095 is kept sticky
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            param_reg <= 12'h000;
            ovf_reg   <= 1'b0;
        end else if (i_rx_valid && state_reg == ST_IDLE) begin
            param_reg <= 12'h000;
            ovf_reg   <= 1'b0;
        end else if (i_rx_valid && state_reg == ST_PARAM
                     && is_digit(i_rx_data)) begin
            if (param_next > POS_MAX)
                ovf_reg <= 1'b1;
            else
                param_reg <= param_next[11:0];
        end
    end

    // wraps naturally at 8 bits, which is the modulo-256 sum
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            sum_reg    <= 8'h00;
            ck_reg     <= 8'h00;
            bypass_reg <= 1'b0;
        end else if (i_rx_valid) begin
            case (state_reg)
                ST_IDLE: begin
                    sum_reg    <= i_rx_data;
                    bypass_reg <= 1'b0;
                end
                ST_CODE_HI, ST_CODE_LO, ST_PARAM:
                    sum_reg <= sum_reg + i_rx_data;
                ST_CK_HI: begin
                    bypass_reg  <= (i_rx_data == CH_NOSUM);
                    ck_reg[7:4] <= hex_val(i_rx_data);
                end
                ST_CK_LO: ck_reg[3:0] <= hex_val(i_rx_data);
                default:  sum_reg <= sum_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one answer per '>' inside a message; value stands until the next one
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_resp_valid <= 1'b0;
            o_resp_error <= 1'b0;
            o_resp_query <= 1'b0;
            o_resp_value <= 12'h000;
        end else begin
            o_resp_valid <= fire;
            if (fire) begin
                o_resp_error <= !good;
                o_resp_query <= good && query_reg && cmd_kind == K_GOTO;
                o_resp_value <= (query_reg && cmd_kind == K_GOTO)
                              ? o_axis_target[cmd_axis] : param_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    mode_e mode_reg [NUM_AXES];
    mode_e slave_pend_reg;
    logic  link_reg, enable_reg;

    // reset leaves motors disabled and the slave unlinked
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            link_reg   <= 1'b0;
            enable_reg <= 1'b0;
        end else begin
            link_reg   <= i_slave_link;
            enable_reg <= i_motor_enable;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_axis_rate    <= '0;
            o_axis_target  <= '0;
            slave_pend_reg <= MODE_STOP;
            for (int a = 0; a < NUM_AXES; a++) mode_reg[a] <= MODE_STOP;
        end else begin
            if (link_reg && !i_slave_link)
                mode_reg[AX_SLAVE] <= slave_pend_reg;
            if (act) begin
                if (cmd_kind == K_GOTO)
                    o_axis_target[cmd_axis] <= param_reg;
                else
                    o_axis_rate[cmd_axis] <= param_reg[7:0];
                if (cmd_axis == AX_SLAVE && link_reg) begin
                    slave_pend_reg <= mode_of(cmd_kind);
                end else begin
                    mode_reg[cmd_axis] <= mode_of(cmd_kind);
                    if (cmd_axis == AX_SLAVE)
                        slave_pend_reg <= mode_of(cmd_kind);
                end
            end
        end
    end

    // a linked slave follows the main zoom drive
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_axis_fwd  <= '0;
            o_axis_rev  <= '0;
            o_axis_goto <= '0;
        end else begin
            for (int a = 0; a < NUM_AXES; a++) begin
                automatic int s = (a == AX_SLAVE && link_reg) ? AX_MAIN : a;
                automatic logic run = enable_reg && mode_reg[s] == MODE_RATE;
                automatic logic [1:0] dir = rate_dir(o_axis_rate[s]);
                o_axis_fwd[a]  <= run && dir[1];
                o_axis_rev[a]  <= run && dir[0];
                o_axis_goto[a] <= enable_reg && mode_reg[s] == MODE_GOTO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    term_answer_a: assert property (fire |=> o_resp_valid)
        else $error("no response after terminator");
    bad_char_a: assert property (i_rx_valid && state_reg == ST_PARAM
        && !is_digit(i_rx_data) && i_rx_data != CH_SEP && !rx_term
        |=> state_reg == ST_FLUSH ##0 !act [*1])
        else $error("bad parameter char not flushed");
    opener_only_a: assert property (state_reg == ST_IDLE && i_rx_valid
        && i_rx_data != CH_INSTR && i_rx_data != CH_QUERY
        |=> state_reg == ST_IDLE)
        else $error("message started without opener");
    bad_code_a: assert property (fire && !cmd_ok
        |=> o_resp_valid && o_resp_error)
        else $error("unknown code not answered with error");
    empty_param_a: assert property (i_rx_valid && state_reg == ST_IDLE
        |=> param_reg == 12'h000)
        else $error("parameter not cleared at message start");
    cksum_err_a: assert property (fire && state_reg == ST_TERM
        && !bypass_reg && ck_reg != sum_reg |=> o_resp_error)
        else $error("checksum mismatch accepted");
    act_on_term_a: assert property (!fire |=> $stable(o_axis_rate)
        && $stable(o_axis_target))
        else $error("command acted before terminator");
    rate_range_a: assert property (fire && cmd_kind != K_GOTO
        && param_reg > RATE_MAX |-> !act ##1 o_resp_error)
        else $error("oversized rate accepted");
    query_only_a: assert property (fire && query_reg
        && cmd_kind == K_GOTO |=> $stable(o_axis_target))
        else $error("query moved an axis");
    main_stop_a: assert property (act && cmd_axis == AX_MAIN
        && cmd_kind == K_RATE_SET |=> mode_reg[AX_MAIN] == MODE_STOP
        ##2 !o_axis_fwd[AX_MAIN] && !o_axis_rev[AX_MAIN])
        else $error("rate set left main zoom running");
    main_run_a: assert property (act && cmd_axis == AX_MAIN
        && cmd_kind == K_RATE_RUN |=> mode_reg[AX_MAIN] == MODE_RATE
        && 12'(o_axis_rate[AX_MAIN]) == $past(param_reg))
        else $error("rate run did not start main zoom");
    deadband_a: assert property (o_axis_fwd[AX_MAIN]
        |-> $past(o_axis_rate[AX_MAIN]) > RATE_MID + DEADBAND)
        else $error("main zoom forward inside deadband");
    slave_hold_a: assert property (link_reg && i_slave_link
        |=> $stable(mode_reg[AX_SLAVE]))
        else $error("linked slave mode changed");

    good_cmd_c: cover property (act ##1 o_resp_valid && !o_resp_error);
    query_c:    cover property (fire && good && query_reg ##1 o_resp_query);
    abandon_c:  cover property (state_reg == ST_PARAM && rx_term);
    unlink_c:   cover property (link_reg && !i_slave_link
                                && slave_pend_reg == MODE_GOTO);
endmodule : lens_cmd_parser

// File: bench/lens_host_model.sv
`timescale 1ns/1ps
module lens_host_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_resp_valid,
    input  wire logic        i_resp_error,
    input  wire logic        i_resp_query,
    input  wire logic [11:0] i_resp_value,
    output logic [7:0]       o_rx_data,
    output logic             o_rx_valid
);
    initial begin
        o_rx_data  = 8'h00;
        o_rx_valid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // one exchange at a time: the next message waits for the answer
    task automatic send(input string msg, input int gap,
                        output logic got, output logic err,
                        output logic qry, output logic [11:0] val);
        got = 1'b0;
        err = 1'b0;
        qry = 1'b0;
        val = 12'h000;
        for (int i = 0; i < msg.len(); i++) begin
            o_rx_data  = msg[i];
            o_rx_valid = 1'b1;
            @(posedge i_ref_clk);
            #1;
            if (gap > 0 || i == msg.len() - 1) begin
                o_rx_valid = 1'b0;
                // idle byte flips so a stale char never looks fresh
                o_rx_data  = ~msg[i];
                if (i < msg.len() - 1) begin
                    repeat (gap) @(posedge i_ref_clk);
                    #1;
                end
            end
        end
        // bounded wait for the single answer
        for (int k = 0; k < 6 && !got; k++) begin
            if (i_resp_valid === 1'b1) begin
                got = 1'b1;
                err = i_resp_error;
                qry = i_resp_query;
                val = i_resp_value;
            end else begin
                @(posedge i_ref_clk);
                #1;
            end
        end
    endtask : send
endmodule : lens_host_model

// File: bench/ascii_lens_command_parser_tb.sv
`timescale 1ns/1ps
module ascii_lens_command_parser_tb;
    import lens_cmd_pkg::*;
    logic                      clk, rst_n, en, link, rx_valid;
    logic [7:0]                rx_data;
    logic                      r_valid, r_err, r_qry, g, q_err, q_qry;
    logic [11:0]               r_val, q_val;
    logic [NUM_AXES-1:0][7:0]  a_rate;
    logic [NUM_AXES-1:0][11:0] a_tgt;
    logic [NUM_AXES-1:0]       a_fwd, a_rev, a_goto;
    logic [31:0]               seed;
    int                        fails, n_compared;

    lens_cmd_parser dut (
        .i_ref_clk      (clk),
        .i_reset_n      (rst_n),
        .i_rx_data      (rx_data),
        .i_rx_valid     (rx_valid),
        .i_motor_enable (en),
        .i_slave_link   (link),
        .o_resp_valid   (r_valid),
        .o_resp_error   (r_err),
        .o_resp_query   (r_qry),
        .o_resp_value   (r_val),
        .o_axis_rate    (a_rate),
        .o_axis_target  (a_tgt),
        .o_axis_fwd     (a_fwd),
        .o_axis_rev     (a_rev),
        .o_axis_goto    (a_goto)
    );
    lens_host_model host (
        .i_ref_clk    (clk),
        .i_resp_valid (r_valid),
        .i_resp_error (r_err),
        .i_resp_query (r_qry),
        .i_resp_value (r_val),
        .o_rx_data    (rx_data),
        .o_rx_valid   (rx_valid)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h00000000);
    endfunction : lfsr

    // ck 0: bypass key, 1: true sum, 2: sum off by one
    function automatic string mk(input byte op, input string body,
                                 input int ck);
        string      s;
        logic [7:0] sum;
        s = $sformatf("%c%s;", op, body);
        sum = 8'h00;
        for (int i = 0; i < s.len(); i++)
            sum = sum + 8'(s[i]);
        if (ck == 0) return {s, "**>"};
        return $sformatf("%s%02X>", s, (ck == 2) ? sum + 8'h01 : sum);
    endfunction : mk

    function automatic logic [1:0] dir_of(input logic [7:0] r);
        if (int'(r) > int'(RATE_MID) + int'(DEADBAND)) return 2'b10;
        if (int'(r) < int'(RATE_MID) - int'(DEADBAND)) return 2'b01;
        return 2'b00;
    endfunction : dir_of

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axis(input int ax, input logic [7:0] r,
                        input logic [11:0] t, input logic [1:0] d,
                        input logic gt);
        check(12'(a_rate[ax]), 12'(r));
        check(a_tgt[ax], t);
        check(12'({a_fwd[ax], a_rev[ax]}), 12'(d));
        check(12'(a_goto[ax]), 12'(gt));
    endtask : axis

    // random pacing: back to back or with idle gaps
    task automatic cmd(input string msg, input logic exp_err);
        seed = lfsr(seed);
        host.send(msg, seed[0] ? 0 : 2, g, q_err, q_qry, q_val);
        check(12'(g), 12'h001);
        check(12'(q_err), 12'(exp_err));
        repeat (3) @(posedge clk);
        #1;
    endtask : cmd

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        #400000;
        fails++;
        $display("BAD t=%0t watchdog expired", $time);
        summarize();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        string       bad[7];
        logic [7:0]  v;
        logic [11:0] t;
        logic [7:0]  edge_r[7];
        fails = 0;
        n_compared = 0;
        seed = 32'h599665D8;
        en = 1'b0;
        link = 1'b0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        for (int ax = 0; ax < NUM_AXES; ax++)
            axis(ax, 8'h00, 12'h000, 2'b00, 1'b0);
        $display("test reset done");

        en = 1'b1;
        cmd(mk(CH_INSTR, "ZR200", 0), 1'b0);
        axis(0, 8'hC8, 12'h000, 2'b10, 1'b0);
        check(q_val, 12'h0C8);
        host.send("<ZS;**", 0, g, q_err, q_qry, q_val);
        check(12'(g), 12'h000);
        check(12'(a_fwd[0]), 12'h001);
        cmd(">", 1'b0);
        axis(0, 8'h00, 12'h000, 2'b00, 1'b0);
        cmd(mk(CH_INSTR, "ZP4095", 1), 1'b0);
        axis(0, 8'h00, 12'hFFF, 2'b00, 1'b1);
        cmd(mk(CH_QUERY, "ZP", 0), 1'b0);
        check(12'(q_qry), 12'h001);
        check(q_val, 12'hFFF);
        cmd(mk(CH_QUERY, "ZR50", 1), 1'b0);
        check(12'(q_qry), 12'h000);
        axis(0, 8'h32, 12'hFFF, 2'b01, 1'b0);
        edge_r = '{8'h74, 8'h75, 8'h7F, 8'h89, 8'h8A, 8'hFF, 8'h00};
        foreach (edge_r[i]) begin
            cmd(mk(CH_INSTR, $sformatf("ZR%0d", edge_r[i]), 0), 1'b0);
            axis(0, edge_r[i], 12'hFFF, dir_of(edge_r[i]), 1'b0);
        end
        cmd(mk(CH_INSTR, "FP123", 0), 1'b0);
        axis(2, 8'h00, 12'h07B, 2'b00, 1'b1);
        cmd(mk(CH_INSTR, "FS", 1), 1'b0);
        axis(2, 8'h00, 12'h07B, 2'b00, 1'b0);
        $display("test commands done");

        bad = '{"<ZR256;**>", "<ZP4096;**>", "<zr1;**>", "<ZX1;**>",
                mk(CH_INSTR, "ZR1", 2), "<ZR1>", "<ZR1;*5>"};
        foreach (bad[i])
            cmd(bad[i], 1'b1);
        axis(0, 8'h00, 12'hFFF, dir_of(8'h00), 1'b0);
        host.send("X>", 0, g, q_err, q_qry, q_val);
        check(12'(g), 12'h000);
        $display("test errors done");

        for (int n = 0; n < 24; n++) begin
            seed = lfsr(seed);
            v = seed[7:0];
            t = seed[19:8];
            if (seed[31]) begin
                cmd(mk(CH_INSTR, $sformatf("ZR%0d", v), int'(seed[30])),
                    1'b0);
                axis(0, v, 12'hFFF, dir_of(v), 1'b0);
            end else begin
                cmd(mk(CH_INSTR, $sformatf("FP%0d", t), int'(seed[30])),
                    1'b0);
                axis(2, 8'h00, t, 2'b00, 1'b1);
            end
        end
        $display("test random done");

        link = 1'b1;
        cmd(mk(CH_INSTR, "ZR200", 0), 1'b0);
        cmd(mk(CH_INSTR, "YR50", 0), 1'b0);
        axis(1, 8'h32, 12'h000, 2'b10, 1'b0);
        cmd(mk(CH_INSTR, "YP100", 1), 1'b0);
        axis(1, 8'h32, 12'h064, 2'b10, 1'b0);
        link = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        axis(1, 8'h32, 12'h064, 2'b00, 1'b1);
        cmd(mk(CH_INSTR, "YS", 0), 1'b0);
        axis(1, 8'h00, 12'h064, 2'b00, 1'b0);
        cmd(mk(CH_QUERY, "YP", 0), 1'b0);
        check(q_val, 12'h064);
        en = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        axis(0, 8'hC8, 12'hFFF, 2'b00, 1'b0);
        $display("test link done");
        summarize();
    end
endmodule : ascii_lens_command_parser_tb
